// ---- hdl/lsd_pkg.sv ----
// What this block does
// R1 - Display RAM takes byte and word accesses
// R2 - Scanning starts automatically once display is on
// R3 - RAM bit mapping depends on duty
// R4 - Lit pixel: common V1/VSS, segment opposite
// R5 - Unlit pixel levels per duty mode
// R6 - Sub modes: only subclock selection keeps display
// R7 - Software picks subclock before sub modes
// R8 - Software keeps frame rate in medium speed
// R9 - Display runs only when activated in run states
// R10 - Standby forces drive supply off
// R11 - Standby stops subclock delivery to display
// R12 - Module standby gates both clocks, stops display
// R13 - Alternation toggles once per frame
// R14 - Four-bit clock select chooses operating clock
// R15 - Deactivate halts display, supply off, registers kept
// R16 - Module clock gate bit, reset value one
`default_nettype none
package lsd_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CTRL2 = 12'h004;
  localparam logic [11:0] ADDR_MSTP = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00C;
  localparam logic [11:0] ADDR_RAM = 12'h100;
  localparam int RAM_WORDS = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int BIT_SUPPLY = 6;
  localparam int BIT_ACT = 5;
  localparam int BIT_DISP = 4;
  localparam logic [1:0] DUTY_RESET = 2'h0;
  localparam logic MSTP_RESET = 1'b1;
  localparam int SEGS = 32;
  localparam int COMS = 4;

  // Drive level code on each electrode.
  typedef enum logic [1:0] {
    LV_VSS = 2'h0,
    LV_V3 = 2'h1,
    LV_V2 = 2'h2,
    LV_V1 = 2'h3
  } lsd_level_t;

  typedef enum logic [1:0] {
    DUTY_STATIC = 2'h0,
    DUTY_HALF = 2'h1,
    DUTY_THIRD = 2'h2,
    DUTY_QUARTER = 2'h3
  } lsd_duty_t;

  // Chip power state as seen by the display block.
  typedef enum logic [7:0] {
    PM_RESET = 8'h01,
    PM_ACTIVE = 8'h02,
    PM_SLEEP = 8'h04,
    PM_WATCH = 8'h08,
    PM_SUBACT = 8'h10,
    PM_SUBSLEEP = 8'h20,
    PM_STANDBY = 8'h40
  } lsd_pmode_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } lsd_apb_req_t;
endpackage
`default_nettype wire

// ---- hdl/lsd_clkdiv.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsd_clkdiv (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Clock sources
  input wire logic sys_tick,
  input wire logic sub_tick,
  input wire logic [3:0] opclk_sel,
  // Result
  output logic op_tick
);
  logic [7:0] sys_cnt_q;
  logic [1:0] sub_cnt_q;
  logic sys_hit;
  logic sub_hit;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      sys_cnt_q <= 8'h00;
    else if (sys_tick)
      sys_cnt_q <= sys_cnt_q + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      sub_cnt_q <= 2'h0;
    else if (sub_tick)
      sub_cnt_q <= sub_cnt_q + 2'h1;
  end

  // Divide ratio 2^(n+1) fires when the low n+1 counter bits are all ones.
  always_comb
  begin
    sys_hit = sys_tick && ((sys_cnt_q | ~((8'h02 << opclk_sel[2:0]) - 8'h01)) == 8'hFF);
    unique case (opclk_sel[1:0])
      2'h0: sub_hit = sub_tick;
      2'h1: sub_hit = sub_tick && sub_cnt_q[0];
      default: sub_hit = sub_tick && (sub_cnt_q == 2'h3);
    endcase
    op_tick = opclk_sel[3] ? sys_hit : sub_hit; // R14
  end
endmodule
`default_nettype wire

// ---- hdl/lsd_top.sv ----
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module lsd_top #(
  parameter int FRAME_DIV = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire lsd_pkg::lsd_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources and power state
  input wire logic sys_tick,
  input wire logic sub_tick,
  input wire lsd_pkg::lsd_pmode_t pmode,
  // Panel drive
  output lsd_pkg::lsd_level_t [lsd_pkg::COMS-1:0] com_level,
  output lsd_pkg::lsd_level_t [lsd_pkg::SEGS-1:0] seg_level,
  output logic drive_supply_on,
  output logic alternation
);
  logic [7:0] ctrl_q;
  logic [1:0] duty_q;
  logic display_module_clock_gate_q;
  logic [31:0] ram_q [lsd_pkg::RAM_WORDS];
  logic [1:0] com_idx_q;
  logic [7:0] sub_q;
  logic alt_q;
  logic running;
  logic sys_ok;
  logic sub_ok;
  logic op_tick;
  logic raw_tick;
  logic wr_en;
  logic rd_en;
  logic in_ram;
  logic [2:0] ram_idx;
  logic [1:0] com_last;
  logic [31:0] prdata_q;
  logic [31:0] rdata_d;
  logic [31:0] row;

  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  assign in_ram = apb_req.paddr[11:5] == lsd_pkg::ADDR_RAM[11:5];
  assign ram_idx = apb_req.paddr[4:2];
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_q;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl_q <= lsd_pkg::CTRL_RESET;
      duty_q <= lsd_pkg::DUTY_RESET;
      display_module_clock_gate_q <= lsd_pkg::MSTP_RESET; // R16
    end
    else if (wr_en && apb_req.pstrb[0])
    begin
      // Clearing activate leaves every register intact.
      unique case (apb_req.paddr)
        lsd_pkg::ADDR_CTRL: ctrl_q <= apb_req.pwdata[7:0]; // R15
        lsd_pkg::ADDR_CTRL2: duty_q <= apb_req.pwdata[1:0];
        lsd_pkg::ADDR_MSTP: display_module_clock_gate_q <= apb_req.pwdata[0]; // R16
        default: ;
      endcase
    end
  end

  // Byte lanes let software store bytes, halfwords or words.
  always_ff @(posedge clk)
  begin
    if (wr_en && in_ram)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (apb_req.pstrb[b])
          ram_q[ram_idx][8*b +: 8] <= apb_req.pwdata[8*b +: 8]; // R1
      end
    end
  end

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (in_ram)
      rdata_d = ram_q[ram_idx]; // R1
    else
      unique case (apb_req.paddr)
        lsd_pkg::ADDR_CTRL: rdata_d = {24'h00_0000, 1'b1, ctrl_q[6:0]};
        lsd_pkg::ADDR_CTRL2: rdata_d = {30'h0000_0000, duty_q};
        lsd_pkg::ADDR_MSTP: rdata_d = {31'h0000_0000, display_module_clock_gate_q};
        lsd_pkg::ADDR_STAT: rdata_d = {28'h000_0000, drive_supply_on, running, alt_q, 1'b0};
        default: rdata_d = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      prdata_q <= 32'h0000_0000;
    else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
      prdata_q <= rdata_d;
  end

  // Power gating of the clock sources.
  always_comb
  begin
    sys_ok = pmode == lsd_pkg::PM_ACTIVE || pmode == lsd_pkg::PM_SLEEP;
    sub_ok = pmode != lsd_pkg::PM_STANDBY && pmode != lsd_pkg::PM_RESET; // R11
    sys_ok = sys_ok && display_module_clock_gate_q; // R12
    sub_ok = sub_ok && display_module_clock_gate_q; // R12
    // A selected source that is not delivered halts the display rather than freezing a phase.
    running = ctrl_q[lsd_pkg::BIT_ACT] && sys_ok_run(pmode)
              && (ctrl_q[3] ? sys_ok : sub_ok); // R6 R9
  end

  function automatic logic sys_ok_run(input lsd_pkg::lsd_pmode_t m);
    return m inside {lsd_pkg::PM_ACTIVE, lsd_pkg::PM_SLEEP, lsd_pkg::PM_WATCH,
                     lsd_pkg::PM_SUBACT, lsd_pkg::PM_SUBSLEEP};
  endfunction

  // System clock runs only in active and sleep; sub modes need a subclock selection.
  lsd_clkdiv u_div (
    .clk(clk),
    .rstn(rstn),
    .sys_tick(sys_tick && sys_ok),
    .sub_tick(sub_tick && sub_ok), // R6
    .opclk_sel(ctrl_q[3:0]),
    .op_tick(raw_tick)
  );

  assign op_tick = raw_tick && running && display_module_clock_gate_q; // R2

  assign com_last = duty_q;

  // Scan commons, and flip alternation after the last common of each frame.
  always_ff @(posedge clk)
  begin
    if (!rstn || !running)
    begin
      com_idx_q <= 2'h0;
      sub_q <= 8'h00;
      alt_q <= 1'b0;
    end
    else if (op_tick)
    begin
      if (sub_q == 8'(FRAME_DIV - 1))
      begin
        sub_q <= 8'h00;
        if (com_idx_q == com_last)
        begin
          com_idx_q <= 2'h0;
          alt_q <= ~alt_q; // R13
        end
        else
          com_idx_q <= com_idx_q + 2'h1;
      end
      else
        sub_q <= sub_q + 8'h01;
    end
  end

  assign row = ctrl_q[lsd_pkg::BIT_DISP] ? ram_q[com_idx_q] : 32'h0000_0000; // R3
  assign alternation = alt_q;
  assign drive_supply_on = ctrl_q[lsd_pkg::BIT_SUPPLY] && ctrl_q[lsd_pkg::BIT_ACT]
                           && pmode != lsd_pkg::PM_STANDBY; // R10 R15

  // Drive levels; a halted display grounds every electrode so no bias remains.
  genvar g;
  generate
    for (g = 0; g < lsd_pkg::COMS; g++)
    begin : g_com
      always_ff @(posedge clk)
      begin
        if (!rstn || !running)
          com_level[g] <= lsd_pkg::LV_VSS;
        else if (duty_q == lsd_pkg::DUTY_STATIC || 2'(g) == com_idx_q)
          com_level[g] <= alt_q ? lsd_pkg::LV_VSS : lsd_pkg::LV_V1; // R4
        else if (duty_q == lsd_pkg::DUTY_HALF)
          com_level[g] <= lsd_pkg::LV_V2; // R5
        else
          com_level[g] <= alt_q ? lsd_pkg::LV_V2 : lsd_pkg::LV_V3; // R5
      end
    end
    for (g = 0; g < lsd_pkg::SEGS; g++)
    begin : g_seg
      always_ff @(posedge clk)
      begin
        if (!rstn || !running)
          seg_level[g] <= lsd_pkg::LV_VSS;
        else if (row[g])
          seg_level[g] <= alt_q ? lsd_pkg::LV_V1 : lsd_pkg::LV_VSS; // R4
        else if (duty_q == lsd_pkg::DUTY_STATIC || duty_q == lsd_pkg::DUTY_HALF)
          seg_level[g] <= alt_q ? lsd_pkg::LV_VSS : lsd_pkg::LV_V1; // R5
        else
          seg_level[g] <= alt_q ? lsd_pkg::LV_V3 : lsd_pkg::LV_V2; // R5
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- bench/lsd_panel.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsd_panel (
  // Electrodes of one pixel
  input wire lsd_pkg::lsd_level_t com,
  input wire lsd_pkg::lsd_level_t seg,
  // Pixel state
  output logic lit
);
  // Only a full swing darkens the pixel; a V2/V3 pair stays below threshold.
  assign lit = {com, seg} inside {4'hC, 4'h3};
endmodule
`default_nettype wire

// ---- bench/lsd_top_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsd_top_chk #(
  parameter int FRAME_DIV = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB
  input wire lsd_pkg::lsd_apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sources
  input wire logic sys_tick,
  input wire logic sub_tick,
  input wire lsd_pkg::lsd_pmode_t pmode,
  // Panel
  input wire lsd_pkg::lsd_level_t [lsd_pkg::COMS-1:0] com_level,
  input wire lsd_pkg::lsd_level_t [lsd_pkg::SEGS-1:0] seg_level,
  input wire logic drive_supply_on,
  input wire logic alternation
);
  logic [6:0] ctl_q;
  logic gate_q;
  wire wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.pstrb[0];
  wire dark = com_level == '0 && seg_level == '0;
  always_ff @(posedge clk)
    if (!rstn) ctl_q <= 7'h00;
    else if (wr && apb_req.paddr == lsd_pkg::ADDR_CTRL) ctl_q <= apb_req.pwdata[6:0];
  always_ff @(posedge clk)
    if (!rstn) gate_q <= 1'b1;
    else if (wr && apb_req.paddr == lsd_pkg::ADDR_MSTP) gate_q <= apb_req.pwdata[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_standby_supply: assert property (pmode == lsd_pkg::PM_STANDBY |-> !drive_supply_on)
    else $error("supply on in standby");
  a_idle_supply: assert property (!ctl_q[5] |-> !drive_supply_on)
    else $error("supply on while idle");
  a_supply_on: assert property (ctl_q[6] && ctl_q[5] && gate_q && pmode == lsd_pkg::PM_ACTIVE
    |-> drive_supply_on) else $error("supply missing");
  a_standby_dark: assert property ((pmode == lsd_pkg::PM_STANDBY) [*3] |-> dark)
    else $error("drive in standby");
  a_gate_dark: assert property ((!gate_q) [*3] |-> dark)
    else $error("drive in module standby");
  a_idle_dark: assert property ((!ctl_q[5]) [*3] |-> dark)
    else $error("drive while idle");
  a_sub_sys_dark: assert property ((pmode == lsd_pkg::PM_SUBACT && ctl_q[3]) [*3] |-> dark)
    else $error("drive without clock");
  a_zero_wait: assert property (apb_req.psel && apb_req.penable |-> pready && !pslverr)
    else $error("access not answered");
  a_alt_frozen: assert property ((!ctl_q[5]) [*3] |-> $stable(alternation))
    else $error("alternation moves while idle");
  a_com_phase: assert property (com_level[0] == lsd_pkg::LV_V1
    |-> !alternation || !$past(alternation)) else $error("V1 in wrong phase");
endmodule
bind lsd_top lsd_top_chk #(.FRAME_DIV(FRAME_DIV)) u_chk (.clk(clk), .rstn(rstn),
  .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sys_tick(sys_tick), .sub_tick(sub_tick), .pmode(pmode), .com_level(com_level),
  .seg_level(seg_level), .drive_supply_on(drive_supply_on), .alternation(alternation));
`default_nettype wire

// ---- bench/tb_lsd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_lsd_top;
  logic clk, rstn, sys_tick, sub_tick, pready, pslverr, supply, alt, lit, slow;
  logic [1:0] tick_cnt;
  logic [31:0] prdata, rd;
  lsd_pkg::lsd_apb_req_t req;
  lsd_pkg::lsd_pmode_t pmode;
  lsd_pkg::lsd_level_t [lsd_pkg::COMS-1:0] com;
  lsd_pkg::lsd_level_t [lsd_pkg::SEGS-1:0] seg;
  int errors, n_tests;
  int n_cyc;
  // Quarter duty with one op tick per common: four ticks of eight clocks between toggles.
  localparam int ALT_CYC = lsd_pkg::COMS * 8;
  lsd_top #(.FRAME_DIV(1)) dut (.clk(clk), .rstn(rstn), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sys_tick(sys_tick), .sub_tick(sub_tick),
    .pmode(pmode), .com_level(com), .seg_level(seg), .drive_supply_on(supply),
    .alternation(alt));
  lsd_panel panel (.com(com[0]), .seg(seg[0]), .lit(lit));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // The subclock runs at half the full-speed system rate.
  always @(posedge clk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    // Medium speed halves the system clock rate.
    sys_tick <= slow ? tick_cnt == 2'h1 : ~sys_tick;
    sub_tick <= tick_cnt == 2'h3;
  end
  task automatic end_sim;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] s);
    int i;
    i = 0;
    @(posedge clk);
    req <= '{a, 1'b1, 1'b0, w, d, s};
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    rd = prdata;
    req <= '0;
    if (i == 20)
    begin
      errors++;
      end_sim();
    end
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0, 4'h0);
    `CHK(rd, e)
  endtask
  task automatic wait_com(input lsd_pkg::lsd_level_t lv);
    int i;
    i = 0;
    // Let a control write reach the flops that drive the electrodes first.
    repeat (2) @(negedge clk);
    while (com[0] !== lv && i < 400)
    begin
      @(negedge clk);
      i++;
    end
    if (i == 400)
    begin
      errors++;
      end_sim();
    end
  endtask
  task automatic alt_period(output int n);
    logic a0;
    int i;
    n = 0;
    i = 0;
    @(negedge clk);
    a0 = alt;
    while (alt === a0 && i < 400)
    begin
      @(negedge clk);
      i++;
    end
    a0 = alt;
    while (alt === a0 && i < 400)
    begin
      @(negedge clk);
      i++;
      n++;
    end
    if (i >= 400)
    begin
      errors++;
      end_sim();
    end
  endtask
  initial
  begin
    {rstn, sys_tick, sub_tick, tick_cnt, errors, n_tests, slow} = '0;
    req = '0;
    pmode = lsd_pkg::PM_ACTIVE;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    chk_rd(lsd_pkg::ADDR_CTRL, 32'h80);
    chk_rd(lsd_pkg::ADDR_MSTP, 32'h1);
    chk_rd(12'h040, 32'h0);
    `CHK({supply, com}, '0)
    apb(lsd_pkg::ADDR_RAM, 1'b1, 32'h1234_5601, 4'hF);
    apb(lsd_pkg::ADDR_RAM, 1'b1, 32'h00FF_0000, 4'h4);
    apb(lsd_pkg::ADDR_RAM + 12'h01C, 1'b1, 32'hA5A5_5A5A, 4'hF);
    chk_rd(lsd_pkg::ADDR_RAM, 32'h12FF_5601);
    chk_rd(lsd_pkg::ADDR_RAM + 12'h01C, 32'hA5A5_5A5A);
    apb(lsd_pkg::ADDR_CTRL, 1'b1, 32'h70, 4'h1);
    for (int d = 0; d < 4; d++)
    begin
      apb(lsd_pkg::ADDR_CTRL2, 1'b1, {30'h0, d[1:0]}, 4'h1);
      wait_com(lsd_pkg::LV_V1);
      `CHK(lit, 1'b1)
      `CHK(seg[1], (d < 2) ? lsd_pkg::LV_V1 : lsd_pkg::LV_V2)
      wait_com(lsd_pkg::LV_VSS);
      `CHK(seg[0], lsd_pkg::LV_V1)
      `CHK(seg[1], (d < 2) ? lsd_pkg::LV_VSS : lsd_pkg::LV_V3)
    end
    apb(lsd_pkg::ADDR_CTRL, 1'b1, 32'h79, 4'h1);
    alt_period(n_cyc);
    `CHK(n_cyc, ALT_CYC)
    slow <= 1'b1;
    apb(lsd_pkg::ADDR_CTRL, 1'b1, 32'h78, 4'h1);
    alt_period(n_cyc);
    `CHK(n_cyc, ALT_CYC)
    slow <= 1'b0;
    apb(lsd_pkg::ADDR_CTRL, 1'b1, 32'h78, 4'h1);
    wait_com(lsd_pkg::LV_V1);
    @(posedge clk) pmode <= lsd_pkg::PM_SUBACT;
    repeat (4) @(negedge clk);
    `CHK({com, seg}, '0)
    apb(lsd_pkg::ADDR_CTRL, 1'b1, 32'h72, 4'h1);
    wait_com(lsd_pkg::LV_V1);
    @(posedge clk) pmode <= lsd_pkg::PM_STANDBY;
    repeat (4) @(negedge clk);
    `CHK(supply, 1'b0)
    `CHK({com, seg}, '0)
    @(posedge clk) pmode <= lsd_pkg::PM_RESET;
    repeat (4) @(negedge clk);
    `CHK(com, '0)
    @(posedge clk) pmode <= lsd_pkg::PM_SLEEP;
    wait_com(lsd_pkg::LV_V1);
    `CHK(supply, 1'b1)
    apb(lsd_pkg::ADDR_MSTP, 1'b1, 32'h0, 4'h1);
    repeat (4) @(negedge clk);
    `CHK(com, '0)
    apb(lsd_pkg::ADDR_MSTP, 1'b1, 32'h1, 4'h1);
    apb(lsd_pkg::ADDR_CTRL, 1'b1, 32'h52, 4'h1);
    repeat (4) @(negedge clk);
    `CHK({supply, com}, '0)
    chk_rd(lsd_pkg::ADDR_CTRL, 32'hD2);
    end_sim();
  end
endmodule
`default_nettype wire
